// [hw/tcr_regs.svh]
`ifndef TCR_REGS_SVH
`define TCR_REGS_SVH

// Register addresses in the special-function register space.
`define TCR_A_CONFIG      8'hc9
`define TCR_A_RELOAD_LOW  8'hca
`define TCR_A_RELOAD_HIGH 8'hcb
`define TCR_A_COUNT_LOW   8'hcc
`define TCR_A_COUNT_HIGH  8'hcd
`define TCR_B_RELOAD_LOW  8'h92
`define TCR_B_RELOAD_HIGH 8'h93
`define TCR_B_COUNT_LOW   8'h94
`define TCR_B_COUNT_HIGH  8'h95
`define TCR_B_CONFIG      8'h96

// Configuration register field positions.
`define TCR_CFG_SRC_LSB   3
`define TCR_CFG_SRC_MSB   4
`define TCR_CFG_TOG_BIT   2
`define TCR_CFG_OE_BIT    1
`define TCR_CFG_DCEN_BIT  0

// Reset values and counter limits.
`define TCR_RESET_BYTE    8'h00
`define TCR_RESET_WORD    16'h0000
`define TCR_COUNT_MAX     16'hffff

// Clock divider ratios.
`define TCR_SYS_DIV       12
`define TCR_EXT_DIV       8
`define TCR_FAST_DIV      2

`endif

// [hw/tcr_pkg.sv]
package tcr_pkg;

    typedef enum logic [1:0] {
        TCR_SRC_DIV12 = 2'b00,
        TCR_SRC_SYS   = 2'b01,
        TCR_SRC_EXT8  = 2'b10,
        TCR_SRC_DIV2  = 2'b11
    } tcr_src_t;

    typedef enum logic [2:0] {
        TCR_REG_CFG = 3'h0,
        TCR_REG_RLL = 3'h1,
        TCR_REG_RLH = 3'h2,
        TCR_REG_CNL = 3'h3,
        TCR_REG_CNH = 3'h4
    } tcr_reg_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] cap;
        tcr_src_t    src;
        logic        tog;
        logic        oe;
        logic        dcen;
        logic        ovf;
    } tcr_chan_t;

    typedef struct packed {
        tcr_chan_t [1:0] ch;
        logic [7:0]      rdata;
    } tcr_top_t;

    typedef struct packed {
        logic [1:0] clk_sync;
        logic       clk_prev;
        logic [1:0] ctl_sync;
        logic       ctl_prev;
        logic [3:0] div_sys;
        logic       div_fast;
        logic [2:0] div_ext;
        logic       tick;
        logic       fall;
    } tcr_tick_t;

endpackage

// [hw/tcr_tick_gen.sv]
`timescale 1ns/1ps
`include "tcr_regs.svh"

module tcr_tick_gen #(
    parameter int SYS_DIV = `TCR_SYS_DIV,
    parameter int EXT_DIV = `TCR_EXT_DIV
) (
    input  logic              clk_i,
    input  logic              rst_i,
    input  tcr_pkg::tcr_src_t src_i,
    input  logic              ext_clk_i,
    input  logic              ctrl_i,
    output logic              tick_o,
    output logic              ctrl_level_o,
    output logic              ctrl_fall_o
);
    import tcr_pkg::*;

    tcr_tick_t s;
    tcr_tick_t next_s;
    logic      ext_rise;

    always_comb begin
        next_s = s;
        next_s.clk_sync = {s.clk_sync[0], ext_clk_i};
        next_s.clk_prev = s.clk_sync[1];
        next_s.ctl_sync = {s.ctl_sync[0], ctrl_i};
        next_s.ctl_prev = s.ctl_sync[1];
        ext_rise = s.clk_sync[1] & ~s.clk_prev;
        next_s.div_sys = (s.div_sys == 4'(SYS_DIV - 1)) ? 4'h0 : s.div_sys + 4'h1;
        next_s.div_fast = ~s.div_fast;
        if (ext_rise) begin
            next_s.div_ext = s.div_ext + 3'h1;
        end
        unique case (src_i)
            TCR_SRC_DIV12: next_s.tick = (s.div_sys == 4'(SYS_DIV - 1));
            TCR_SRC_SYS:   next_s.tick = 1'b1;
            TCR_SRC_EXT8:  next_s.tick = ext_rise & (s.div_ext == 3'(EXT_DIV - 1));
            TCR_SRC_DIV2:  next_s.tick = s.div_fast;
        endcase
        next_s.fall = s.ctl_prev & ~s.ctl_sync[1];
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick_o       = s.tick;
    assign ctrl_level_o = s.ctl_sync[1];
    assign ctrl_fall_o  = s.fall;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sys_div_period_a: assert property (
        (tick_o && src_i == TCR_SRC_DIV12 && $past(src_i) == TCR_SRC_DIV12)
        |-> ##1 !tick_o ##11 (tick_o || src_i != TCR_SRC_DIV12))
        else $error("divide-by-twelve tick period wrong");
    fast_div_alt_a: assert property (
        (src_i == TCR_SRC_DIV2 && $past(src_i) == TCR_SRC_DIV2 && tick_o)
        |=> (!tick_o || src_i != TCR_SRC_DIV2))
        else $error("divide-by-two tick not alternating");
    cover_ext_tick_c: cover property (src_i == TCR_SRC_EXT8 && tick_o);

endmodule // tcr_tick_gen

// [hw/tcr_timer_pair.sv]
`timescale 1ns/1ps
`include "tcr_regs.svh"

// How it works
// - Two-bit source picks system clock /12, /1, external /8 synchronised, or /2.
// - Toggle state bit reads the present output level; writing forces that level.
// - Toggle output enable drives the toggle bit onto the pin; it is a 50% square wave only in auto-reload mode.
// - Toggle output reaches the pin only while the enable bit is 1.
// - Count-down enable at 0 counts up whatever the control input does.
// - Count-down enable at 1: control input 0 counts down, 1 counts up.
// - Capture mode copies the counter low byte into the low reload byte.
// - Capture mode copies the counter high byte into the high reload byte.
// - Reload mode: low reload byte is loaded into the counter low byte.
// - Reload mode: high reload byte is loaded into the counter high byte.
// - Capture/reload select 0 means auto-reload, 1 means capture.
// - Function select 0 counts the chosen clock, 1 counts control input falling edges.
// - Run control 0 stops counting (an external reload on a control falling edge still loads the counter), 1 lets it count.
// - With external enable, a control falling edge in capture mode captures the count.

module tcr_timer_pair (
    input  logic       CLK_I,
    input  logic       RST_I,
    input  logic [7:0] SFR_ADDR_I,
    input  logic       SFR_WR_I,
    input  logic       SFR_RD_I,
    input  logic [7:0] SFR_WDATA_I,
    output logic [7:0] SFR_RDATA_O,
    input  logic       EXT_CLK_I,
    input  logic [1:0] EXT_CTRL_I,
    input  logic [1:0] RUN_I,
    input  logic [1:0] COUNTER_SEL_I,
    input  logic [1:0] CAPTURE_SEL_I,
    input  logic [1:0] EXT_EN_I,
    output logic [1:0] TOGGLE_O,
    output logic [1:0] TOGGLE_OE_O,
    output logic [1:0] OVERFLOW_O
);
    import tcr_pkg::*;

    tcr_top_t   s;
    tcr_top_t   next_s;
    tcr_chan_t  c;
    logic [1:0] tick;
    logic [1:0] level;
    logic [1:0] fall;
    logic       evt;
    logic       down;
    logic       wrap;
    logic       cap_evt;

    function automatic logic [7:0] reg_addr(input int ch, input tcr_reg_t k);
        unique case (k)
            TCR_REG_CFG: reg_addr = (ch == 0) ? `TCR_A_CONFIG : `TCR_B_CONFIG;
            TCR_REG_RLL: reg_addr = (ch == 0) ? `TCR_A_RELOAD_LOW : `TCR_B_RELOAD_LOW;
            TCR_REG_RLH: reg_addr = (ch == 0) ? `TCR_A_RELOAD_HIGH : `TCR_B_RELOAD_HIGH;
            TCR_REG_CNL: reg_addr = (ch == 0) ? `TCR_A_COUNT_LOW : `TCR_B_COUNT_LOW;
            TCR_REG_CNH: reg_addr = (ch == 0) ? `TCR_A_COUNT_HIGH : `TCR_B_COUNT_HIGH;
            default:     reg_addr = `TCR_RESET_BYTE;
        endcase
    endfunction

    function automatic logic [7:0] cfg_byte(input tcr_chan_t ch);
        cfg_byte = {3'h0, ch.src, ch.tog, ch.oe, ch.dcen};
    endfunction

    function automatic logic [7:0] read_byte(input tcr_top_t st, input logic [7:0] a);
        read_byte = `TCR_RESET_BYTE;
        for (int i = 0; i < 2; i++) begin
            if (a == reg_addr(i, TCR_REG_CFG)) read_byte = cfg_byte(st.ch[i]);
            if (a == reg_addr(i, TCR_REG_RLL)) read_byte = st.ch[i].cap[7:0];
            if (a == reg_addr(i, TCR_REG_RLH)) read_byte = st.ch[i].cap[15:8];
            if (a == reg_addr(i, TCR_REG_CNL)) read_byte = st.ch[i].cnt[7:0];
            if (a == reg_addr(i, TCR_REG_CNH)) read_byte = st.ch[i].cnt[15:8];
        end
    endfunction

    for (genvar g = 0; g < 2; g++) begin : g_tick
        tcr_tick_gen u_tick (
            .clk_i        (CLK_I),
            .rst_i        (RST_I),
            .src_i        (s.ch[g].src),
            .ext_clk_i    (EXT_CLK_I),
            .ctrl_i       (EXT_CTRL_I[g]),
            .tick_o       (tick[g]),
            .ctrl_level_o (level[g]),
            .ctrl_fall_o  (fall[g])
        );
    end

    always_comb begin
        next_s  = s;
        c       = '0;
        evt     = 1'b0;
        down    = 1'b0;
        wrap    = 1'b0;
        cap_evt = 1'b0;
        for (int i = 0; i < 2; i++) begin
            c = s.ch[i];
            evt = RUN_I[i] & (COUNTER_SEL_I[i] ? fall[i] : tick[i]);
            down = c.dcen & ~level[i];
            wrap = 1'b0;
            if (evt) begin
                if (down) begin
                    if (c.cnt == c.cap) begin
                        c.cnt = `TCR_COUNT_MAX;
                        wrap = 1'b1;
                    end else begin
                        c.cnt = c.cnt - 16'h1;
                    end
                end else if (c.cnt == `TCR_COUNT_MAX) begin
                    c.cnt = CAPTURE_SEL_I[i] ? `TCR_RESET_WORD : s.ch[i].cap;
                    wrap = 1'b1;
                end else begin
                    c.cnt = c.cnt + 16'h1;
                end
            end
            if (EXT_EN_I[i] && !CAPTURE_SEL_I[i] && !c.dcen && fall[i]) begin
                c.cnt = s.ch[i].cap;
            end
            cap_evt = EXT_EN_I[i] & CAPTURE_SEL_I[i] & fall[i];
            if (cap_evt) begin
                c.cap = s.ch[i].cnt;
            end
            if (wrap && !CAPTURE_SEL_I[i]) begin
                c.tog = ~c.tog;
            end
            c.ovf = wrap;
            if (SFR_WR_I) begin
                if (SFR_ADDR_I == reg_addr(i, TCR_REG_CFG)) begin
                    c.src  = tcr_src_t'(SFR_WDATA_I[`TCR_CFG_SRC_MSB:`TCR_CFG_SRC_LSB]);
                    c.tog  = SFR_WDATA_I[`TCR_CFG_TOG_BIT];
                    c.oe   = SFR_WDATA_I[`TCR_CFG_OE_BIT];
                    c.dcen = SFR_WDATA_I[`TCR_CFG_DCEN_BIT];
                end
                if (SFR_ADDR_I == reg_addr(i, TCR_REG_RLL) && !cap_evt) c.cap[7:0] = SFR_WDATA_I;
                if (SFR_ADDR_I == reg_addr(i, TCR_REG_RLH) && !cap_evt) c.cap[15:8] = SFR_WDATA_I;
                if (SFR_ADDR_I == reg_addr(i, TCR_REG_CNL)) c.cnt[7:0] = SFR_WDATA_I;
                if (SFR_ADDR_I == reg_addr(i, TCR_REG_CNH)) c.cnt[15:8] = SFR_WDATA_I;
            end
            next_s.ch[i] = c;
        end
        if (SFR_RD_I) begin
            next_s.rdata = read_byte(s, SFR_ADDR_I);
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign SFR_RDATA_O = s.rdata;
    for (genvar g = 0; g < 2; g++) begin : g_pins
        assign TOGGLE_O[g]    = s.ch[g].tog;
        assign TOGGLE_OE_O[g] = s.ch[g].oe;
        assign OVERFLOW_O[g]  = s.ch[g].ovf;
    end

    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    logic [1:0] wr_cnt;
    logic [1:0] wr_cfg;
    logic [1:0] wr_cap;
    logic [1:0] ext_rl;
    logic [1:0] ev;

    for (genvar g = 0; g < 2; g++) begin : g_chk
        assign wr_cnt[g] = SFR_WR_I && (SFR_ADDR_I == reg_addr(g, TCR_REG_CNL)
                           || SFR_ADDR_I == reg_addr(g, TCR_REG_CNH));
        assign wr_cfg[g] = SFR_WR_I && SFR_ADDR_I == reg_addr(g, TCR_REG_CFG);
        assign wr_cap[g] = SFR_WR_I && (SFR_ADDR_I == reg_addr(g, TCR_REG_RLL)
                           || SFR_ADDR_I == reg_addr(g, TCR_REG_RLH));
        assign ext_rl[g] = EXT_EN_I[g] && !CAPTURE_SEL_I[g] && !s.ch[g].dcen && fall[g];
        assign ev[g]     = RUN_I[g] && (COUNTER_SEL_I[g] ? fall[g] : tick[g]);

        count_up_a: assert property ((ev[g] && !s.ch[g].dcen && !wr_cnt[g] && !ext_rl[g]
            && s.ch[g].cnt != `TCR_COUNT_MAX) |=> s.ch[g].cnt == $past(s.ch[g].cnt) + 16'h1)
            else $error("counter did not count up");
        count_down_a: assert property ((ev[g] && s.ch[g].dcen && !level[g] && !wr_cnt[g]
            && s.ch[g].cnt != s.ch[g].cap) |=> s.ch[g].cnt == $past(s.ch[g].cnt) - 16'h1)
            else $error("counter did not count down");
        run_stop_a: assert property ((!RUN_I[g] && !wr_cnt[g] && !ext_rl[g])
            |=> $stable(s.ch[g].cnt))
            else $error("stopped counter moved");
        counter_fn_a: assert property ((COUNTER_SEL_I[g] && !fall[g] && !wr_cnt[g])
            |=> $stable(s.ch[g].cnt))
            else $error("counter moved without control edge");
        capture_low_a: assert property ((EXT_EN_I[g] && CAPTURE_SEL_I[g] && fall[g])
            |=> s.ch[g].cap[7:0] == $past(s.ch[g].cnt[7:0]))
            else $error("low byte not captured");
        capture_high_a: assert property ((EXT_EN_I[g] && CAPTURE_SEL_I[g] && fall[g])
            |=> s.ch[g].cap[15:8] == $past(s.ch[g].cnt[15:8]))
            else $error("high byte not captured");
        no_capture_a: assert property ((!EXT_EN_I[g] && !wr_cap[g]) |=> $stable(s.ch[g].cap))
            else $error("reload bytes changed without cause");
        reload_low_a: assert property ((ev[g] && !CAPTURE_SEL_I[g] && !s.ch[g].dcen
            && s.ch[g].cnt == `TCR_COUNT_MAX && !wr_cnt[g])
            |=> OVERFLOW_O[g] && s.ch[g].cnt[7:0] == $past(s.ch[g].cap[7:0]))
            else $error("low reload byte not loaded");
        reload_high_a: assert property ((ev[g] && !CAPTURE_SEL_I[g] && !s.ch[g].dcen
            && s.ch[g].cnt == `TCR_COUNT_MAX && !wr_cnt[g])
            |=> s.ch[g].cnt[15:8] == $past(s.ch[g].cap[15:8]))
            else $error("high reload byte not loaded");
        capture_wrap_a: assert property ((ev[g] && CAPTURE_SEL_I[g] && !s.ch[g].dcen
            && s.ch[g].cnt == `TCR_COUNT_MAX && !wr_cnt[g] && !ext_rl[g])
            |=> s.ch[g].cnt == `TCR_RESET_WORD)
            else $error("capture mode overflow did not clear");
        toggle_flip_a: assert property ((OVERFLOW_O[g] && !$past(CAPTURE_SEL_I[g])
            && !$past(wr_cfg[g])) |-> TOGGLE_O[g] != $past(TOGGLE_O[g]))
            else $error("toggle did not invert on reload");
        toggle_cause_a: assert property ($changed(TOGGLE_O[g])
            |-> OVERFLOW_O[g] || $past(wr_cfg[g]))
            else $error("toggle changed without overflow or write");
        toggle_read_a: assert property ((SFR_RD_I && SFR_ADDR_I == reg_addr(g, TCR_REG_CFG))
            |=> SFR_RDATA_O[`TCR_CFG_TOG_BIT] == $past(TOGGLE_O[g]))
            else $error("toggle state read wrong");
        pin_enable_a: assert property (wr_cfg[g]
            |=> TOGGLE_OE_O[g] == $past(SFR_WDATA_I[`TCR_CFG_OE_BIT]))
            else $error("toggle enable not applied");
        reset_clear_a: assert property ($past(RST_I) |-> s.ch[g].cnt == `TCR_RESET_WORD
            && s.ch[g].cap == `TCR_RESET_WORD && s.ch[g].src == TCR_SRC_DIV12 && !s.ch[g].dcen)
            else $error("registers not cleared by reset");
        cover_square_c: cover property (TOGGLE_OE_O[g] && OVERFLOW_O[g] && !CAPTURE_SEL_I[g]);
        cover_capture_c: cover property (EXT_EN_I[g] && CAPTURE_SEL_I[g] && fall[g]);
        cover_down_c: cover property (OVERFLOW_O[g] && s.ch[g].dcen);
    end

endmodule // tcr_timer_pair

// [test/tcr_pin_model.sv]
`timescale 1ns/1ps

// Board side of the timer pair: control pins, shared external clock and pulled-up toggle pins.
module tcr_pin_model (
    input  logic       clk_i,
    input  logic [1:0] toggle_i,
    input  logic [1:0] oe_i,
    output logic [1:0] ctrl_o,
    output logic       ext_clk_o,
    output logic [1:0] pin_o
);
    logic ext_run = 1'b0;

    // A pin that the timer does not drive rests at its pull-up level.
    assign pin_o = (oe_i & toggle_i) | ~oe_i;

    // The external clock runs only while a test asks for it, off the system clock phase.
    initial begin
        ctrl_o = 2'h3;
        ext_clk_o = 1'b0;
        #3;
        forever #16 ext_clk_o = ext_run ? ~ext_clk_o : 1'b0;
    end

    task automatic falls(input int idx, input int n);
        for (int i = 0; i < n; i++) begin
            repeat (6) @(posedge clk_i);
            ctrl_o[idx] <= 1'b0;
            repeat (6) @(posedge clk_i);
            ctrl_o[idx] <= 1'b1;
        end
    endtask

    task automatic level(input int idx, input logic v);
        ctrl_o[idx] <= v;
        repeat (5) @(posedge clk_i);
    endtask

    // Starts or stops the shared external clock; it rests low while stopped.
    task automatic ext_clock(input logic on);
        ext_run = on;
    endtask
endmodule // tcr_pin_model

// [test/tcr_timer_pair_tb.sv]
`timescale 1ns/1ps

module tcr_timer_pair_tb;
    import tcr_pkg::*;
    typedef struct { logic [7:0] a; logic [7:0] d; logic [7:0] e; } tcr_row_t;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [1:0] run = 2'h0;
    logic [1:0] csel = 2'h0;
    logic [1:0] cap = 2'h0;
    logic [1:0] external_input_enable = 2'h0;
    logic [7:0] rdata;
    logic [1:0] tog, oe, ovf, ctrl, pin;
    logic       ext_clk;
    int         n_errors = 0;
    int         cmp_count = 0;
    tcr_row_t   rows [8] = '{'{8'hca, 8'ha5, 8'ha5}, '{8'hcb, 8'h5a, 8'h5a}, '{8'h92, 8'h3c, 8'h3c},
        '{8'h93, 8'hc3, 8'hc3}, '{8'hcc, 8'h34, 8'h34}, '{8'hc9, 8'hf9, 8'h19}, '{8'h96, 8'he6, 8'h06},
        '{8'h55, 8'h77, 8'h00}};

    always #4 clk = ~clk;

    tcr_timer_pair u_tcr_timer_pair (.CLK_I(clk), .RST_I(rst), .SFR_ADDR_I(addr), .SFR_WR_I(wr), .SFR_RD_I(rd),
        .SFR_WDATA_I(wdata), .SFR_RDATA_O(rdata), .EXT_CLK_I(ext_clk), .EXT_CTRL_I(ctrl), .RUN_I(run),
        .COUNTER_SEL_I(csel), .CAPTURE_SEL_I(cap), .EXT_EN_I(external_input_enable), .TOGGLE_O(tog), .TOGGLE_OE_O(oe),
        .OVERFLOW_O(ovf));
    tcr_pin_model u_tcr_pin_model (.clk_i(clk), .toggle_i(tog), .oe_i(oe), .ctrl_o(ctrl), .ext_clk_o(ext_clk),
        .pin_o(pin));

    task automatic check(input string name, input int lo, input int hi, input logic [15:0] got);
        logic ok;
        ok = (got >= lo) && (got <= hi);
        cmp_count++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("ERROR %s expected %0h seen %0h", name, lo, got);
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic rcnt(input logic [7:0] a, output logic [15:0] w);
        rreg(a, w[7:0]);
        rreg(a + 8'h01, w[15:8]);
    endtask

    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        run <= 2'h0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // The tests take under a thousand cycles; twenty-five thousand means a hang.
    initial begin
        #200000;
        n_errors++;
        conclude();
    end

    initial begin
        logic [7:0]  v;
        logic [15:0] w, w2;
        int          hi, nov, ntg;
        logic        p;
        static int         rate [4]   = '{8, 96, 3, 48};
        static logic [7:0] dcfg [4]   = '{8'h08, 8'h09, 8'h09, 8'h09};
        static logic [7:0] dstart [4] = '{8'h40, 8'h40, 8'h40, 8'h04};
        static int         dexp [4]   = '{16'h4a, 16'h36, 16'h4a, 16'hfffa};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            rreg(rows[i].a, v);
            check("reset value", 0, 0, v);
        end
        foreach (rows[i]) begin
            wreg(rows[i].a, rows[i].d);
            rreg(rows[i].a, v);
            check("readback", rows[i].e, rows[i].e, v);
        end
        check("toggle level", 2, 2, tog);
        check("pin level", 3, 3, pin);
        wreg(8'hc9, 8'h02);
        #1;
        check("pin driven", 2, 2, pin);
        wreg(8'hc9, 8'h00);
        #1;
        check("pin released", 3, 3, pin);
        do_reset();
        rreg(8'h96, v);
        check("cfg after reset", 0, 0, {oe, v});
        wreg(8'hca, 8'hfe);
        wreg(8'hcb, 8'hff);
        wreg(8'hcc, 8'hff);
        wreg(8'hcd, 8'hff);
        wreg(8'hc9, 8'h0a);
        run <= 2'h1;
        repeat (4) @(posedge clk);
        #1;
        p = pin[0];
        nov = 0;
        ntg = 0;
        hi = 0;
        repeat (40) begin
            @(posedge clk);
            #1;
            nov += ovf[0];
            ntg += (pin[0] != p);
            hi += pin[0];
            p = pin[0];
        end
        run <= 2'h0;
        check("overflows", 20, 20, nov[15:0]);
        check("toggles", 20, 20, ntg[15:0]);
        check("high cycles", 20, 20, hi[15:0]);
        rreg(8'hcd, v);
        check("reloaded high", 8'hff, 8'hff, v);
        rcnt(8'hca, w);
        check("reload kept", 16'hfffe, 16'hfffe, w);
        rcnt(8'hcc, w);
        repeat (20) @(posedge clk);
        rcnt(8'hcc, w2);
        check("stopped count", w, w, w2);
        cap <= 2'h1;
        for (int s = 0; s < 4; s++) begin
            wreg(8'hc9, {3'h0, s[1:0], 3'h0});
            wreg(8'hcc, 8'h00);
            wreg(8'hcd, 8'h00);
            u_tcr_pin_model.ext_clock(s == 2);
            repeat (8) @(posedge clk);
            run <= 2'h1;
            repeat (96) @(posedge clk);
            run <= 2'h0;
            repeat (4) @(posedge clk);
            rcnt(8'hcc, w);
            check("source rate", rate[s] - 1, rate[s] + 1, w);
        end
        u_tcr_pin_model.ext_clock(1'b0);
        wreg(8'hcc, 8'hff);
        wreg(8'hcd, 8'hff);
        run <= 2'h1;
        repeat (4) @(posedge clk);
        run <= 2'h0;
        rcnt(8'hcc, w);
        check("capture wrap", 16'h0001, 16'h0001, w);
        for (int k = 0; k < 4; k++) begin
            wreg(8'h96, dcfg[k]);
            u_tcr_pin_model.level(1, k == 2);
            wreg(8'h94, dstart[k]);
            wreg(8'h95, 8'h00);
            run <= 2'h2;
            repeat (10) @(posedge clk);
            run <= 2'h0;
            rcnt(8'h94, w);
            check("direction", dexp[k] - 1, dexp[k] + 1, w);
        end
        wreg(8'hcc, 8'hfe);
        wreg(8'hcd, 8'h12);
        wreg(8'hca, 8'h00);
        wreg(8'hcb, 8'h00);
        csel <= 2'h1;
        external_input_enable <= 2'h1;
        run <= 2'h1;
        u_tcr_pin_model.falls(0, 5);
        repeat (6) @(posedge clk);
        run <= 2'h0;
        rcnt(8'hcc, w);
        check("edge count", 16'h1303, 16'h1303, w);
        rreg(8'hca, v);
        check("capture low", 8'h02, 8'h02, v);
        rreg(8'hcb, v);
        check("capture high", 8'h13, 8'h13, v);
        conclude();
    end
endmodule // tcr_timer_pair_tb
